/* hdl/pcm_cycle_mode.sv */
`timescale 1ns/100ps
`default_nettype none

// Function
// [R1] The cycle overflow flag sets when the main counter carries out of bit 8, 9, 10 or 11; the code sets it on a carry out of bit 7, 8, 9 or 10.
// [R2] The flag may be set by hardware or software and only software clears it.
// [R3] Bits 4 to 2 of the cycle configuration register read zero and ignore writes.
// [R4] Cycle length code 00, 01, 10, 11 selects 8, 9, 10 or 11 bits.
// [R5] The selected length is shared by every PWM module not in 16-bit mode.
// [R6] A module in 16-bit PWM ignores the selector and uses the full 16-bit cycle.
// [R7] With PWM enabled, mode bit 7 picks 8 to 11-bit (0) or 16-bit (1) PWM.
// [R8] Mode bit 6 enables the module's comparator against the main counter.
// [R9] Mode bit 5 enables capture on a rising edge at the module's input.
// [R10] Each of the three modules has an 8-bit read/write mode register reset to zero.
// [R11] Mode bit 4 enables capture on a falling edge at the module's input.
// [R12] With the overflow interrupt enabled, a set overflow flag requests an interrupt.
// [R13] While the watchdog is enabled, writes to the third mode register are ignored.
// [R14] A hardware overflow in the same cycle as a software clear leaves the flag set.
module pcm_cycle_mode
  import pcm_pkg::*;
#(
  parameter int unsigned NUM_MODULES = 3, // Capture/compare modules.
  parameter int unsigned WDOG_MODULE = 2  // Module that doubles as watchdog.
)
(
  input  wire logic                        clk_sys_in,            // System clock, 20 MHz.
  input  wire logic                        rstn_in,               // Async reset, active low.
  input  wire logic [ADDR_W-1:0]           reg_addr_in,           // Register address.
  input  wire logic [DATA_W-1:0]           reg_wdata_in,          // Register write data.
  input  wire logic                        reg_wr_in,             // Write strobe.
  input  wire logic                        reg_rd_in,             // Read strobe.
  output logic      [DATA_W-1:0]           reg_rdata_out,         // Read data, one cycle later.
  input  wire logic [CNT_W-1:0]            main_counter_in,       // Main counter value.
  input  wire logic [NUM_MODULES-1:0]      capture_pin_in,        // Module capture inputs.
  output logic                             cycle_overflow_flag_out, // Sticky overflow flag.
  output logic                             counter_irq_out,       // Counter-array request.
  output logic                             irq_out,               // Masked status interrupt.
  output logic                             watchdog_enable_out,   // Watchdog mode active.
  output logic                             auto_reload_select_out, // Reload register select.
  output logic      [NUM_MODULES-1:0]      comparator_enable_out, // Comparator enables.
  output logic      [NUM_MODULES-1:0]      match_enable_out,      // Match enables.
  output logic      [NUM_MODULES-1:0]      toggle_enable_out,     // Toggle enables.
  output logic      [NUM_MODULES-1:0]      pwm_enable_out,        // PWM enables.
  output logic      [NUM_MODULES-1:0]      wide_pwm_select_out,   // 16-bit PWM selects.
  output logic      [NUM_MODULES-1:0]      ccf_irq_enable_out,    // Module flag irq enables.
  output logic      [NUM_MODULES-1:0]      capture_strobe_out,    // Capture now, one pulse.
  output logic      [NUM_MODULES*BITS_W-1:0] pwm_cycle_bits_out,  // Cycle bits per module.
  output logic      [NUM_MODULES-1:0]      pwm_cycle_end_out      // Cycle wrap, one pulse.
);

  // ----------
  // Declarations
  // ----------
  logic [7:0]           mode_reg [NUM_MODULES];
  logic [1:0]           cycle_length_select_reg;
  logic                 cycle_overflow_flag_reg;
  logic                 cycle_overflow_irq_enable_reg;
  logic                 auto_reload_select_reg;
  logic                 watchdog_enable_reg;
  logic [IRQ_W-1:0]     irq_status_reg;
  logic [IRQ_W-1:0]     irq_status_next;
  logic [IRQ_W-1:0]     irq_mask_reg;
  logic [DATA_W-1:0]    rdata_reg;
  logic [DATA_W-1:0]    rdata_next;
  logic [NUM_MODULES-1:0] rise_edge;
  logic [NUM_MODULES-1:0] fall_edge;
  logic [NUM_MODULES-1:0] capture_strobe_reg;
  logic [NUM_MODULES-1:0] cycle_end_reg;
  logic [BITS_W-1:0]    cycle_bits_reg [NUM_MODULES];
  logic [NUM_MODULES-1:0] mode_wr_hit;
  logic                 cfg_wr;
  logic                 cycle_overflow_flag_next;
  logic [NUM_MODULES-1:0] rise_strobe_src;

  pcm_ovf_if ovf_bus ();

  // One-hot match of an address against the mode register block.
  function automatic logic [NUM_MODULES-1:0] mode_decode(input logic [ADDR_W-1:0] a);
    logic [NUM_MODULES-1:0] hit;
    hit = '0;
    for (int k = 0; k < NUM_MODULES; k++)
    begin
      hit[k] = (a == MODE0_ADDR + 8'(k));
    end
    return hit;
  endfunction

  // ----------
  // Overflow detection
  // ----------
  assign ovf_bus.count = main_counter_in;
  assign ovf_bus.sel   = cycle_length_select_reg;

  pcm_ovf_detect u_ovf_detect (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .ovf        (ovf_bus.detector)
  );

  // ----------
  // Capture inputs
  // ----------
  // Pins are asynchronous, so each passes three flops; an edge is only
  // accepted once the last two stages agree, which rejects a one-cycle glitch.
  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g++)
    begin : g_capture
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic stable_reg;
      logic changed;

      assign changed = (s2_reg == s3_reg) && (s3_reg != stable_reg);

      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          s1_reg     <= 1'b0;
          s2_reg     <= 1'b0;
          s3_reg     <= 1'b0;
          stable_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= capture_pin_in[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (changed)
          begin
            stable_reg <= s3_reg;
          end
        end
      end

      assign rise_edge[g] = changed && s3_reg;
      assign fall_edge[g] = changed && !s3_reg;

      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          capture_strobe_reg[g] <= 1'b0;
        end
        else
        begin
          capture_strobe_reg[g] <= (rise_edge[g] && mode_reg[g][MODE_RISE_BIT]) || // [R9]
                                   (fall_edge[g] && mode_reg[g][MODE_FALL_BIT]);   // [R11]
        end
      end
    end
  endgenerate

  // ----------
  // Module mode registers
  // ----------
  assign mode_wr_hit = reg_wr_in ? mode_decode(reg_addr_in) : '0;

  generate
    for (g = 0; g < NUM_MODULES; g++)
    begin : g_mode
      // While the watchdog is enabled, the watchdog module's setup is frozen so a stray write cannot disarm it.
      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          mode_reg[g] <= MODE_RESET; // [R10]
        end
        else if (mode_wr_hit[g] && !(g == WDOG_MODULE && watchdog_enable_reg)) // [R13]
        begin
          mode_reg[g] <= reg_wdata_in; // [R10]
        end
      end

      // Shared short length unless this module's mode bit 7 selects 16-bit PWM.
      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          cycle_bits_reg[g] <= CYCLE_BASE_BITS;
          cycle_end_reg[g]  <= 1'b0;
        end
        else if (mode_reg[g][MODE_WIDE_BIT]) // [R7]
        begin
          cycle_bits_reg[g] <= WIDE_CYCLE_BITS; // [R6]
          cycle_end_reg[g]  <= mode_reg[g][MODE_PWM_BIT] && ovf_bus.full_wrap; // [R6]
        end
        else
        begin
          cycle_bits_reg[g] <= CYCLE_BASE_BITS + {3'h0, cycle_length_select_reg}; // [R4] [R5]
          cycle_end_reg[g]  <= mode_reg[g][MODE_PWM_BIT] && ovf_bus.sel_wrap;     // [R5]
        end
      end

      assign comparator_enable_out[g] = mode_reg[g][MODE_CMP_BIT]; // [R8]
      assign match_enable_out[g]      = mode_reg[g][MODE_MATCH_BIT];
      assign toggle_enable_out[g]     = mode_reg[g][MODE_TOGGLE_BIT];
      assign pwm_enable_out[g]        = mode_reg[g][MODE_PWM_BIT];
      assign wide_pwm_select_out[g]   = mode_reg[g][MODE_WIDE_BIT]; // [R7]
      assign ccf_irq_enable_out[g]    = mode_reg[g][MODE_CCFIE_BIT];
      assign pwm_cycle_bits_out[g*BITS_W +: BITS_W] = cycle_bits_reg[g];
    end
  endgenerate

  assign capture_strobe_out = capture_strobe_reg;
  assign pwm_cycle_end_out  = cycle_end_reg;

  // ----------
  // Cycle configuration register
  // ----------
  assign cfg_wr = reg_wr_in && (reg_addr_in == CYCLE_CFG_ADDR);

  // A write of one sets the flag and a write of zero clears it, but a carry in
  // the same cycle wins so that no overflow is lost.
  always_comb
  begin
    cycle_overflow_flag_next = cycle_overflow_flag_reg;
    if (cfg_wr)
    begin
      cycle_overflow_flag_next = reg_wdata_in[CFG_OVF_BIT]; // [R2]
    end
    if (ovf_bus.sel_wrap)
    begin
      cycle_overflow_flag_next = 1'b1; // [R1] [R14]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cycle_overflow_flag_reg <= CFG_BIT_RESET;
    end
    else
    begin
      cycle_overflow_flag_reg <= cycle_overflow_flag_next; // [R2]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cycle_length_select_reg       <= CFG_SEL_RESET;
      cycle_overflow_irq_enable_reg <= CFG_BIT_RESET;
      auto_reload_select_reg        <= CFG_BIT_RESET;
    end
    else if (cfg_wr)
    begin
      // Bits 4 to 2 have no storage, so writes there vanish.
      cycle_length_select_reg       <= reg_wdata_in[CFG_SEL_LSB +: CFG_SEL_W]; // [R3] [R4]
      cycle_overflow_irq_enable_reg <= reg_wdata_in[CFG_IRQ_EN_BIT];
      auto_reload_select_reg        <= reg_wdata_in[CFG_ARSEL_BIT];
    end
  end

  // ----------
  // Watchdog control
  // ----------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      watchdog_enable_reg <= CFG_BIT_RESET;
    end
    else if (reg_wr_in && (reg_addr_in == WDOG_CTRL_ADDR))
    begin
      watchdog_enable_reg <= reg_wdata_in[WDOG_EN_BIT]; // [R13]
    end
  end

  // ----------
  // Interrupt status and mask
  // ----------
  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (reg_wr_in && (reg_addr_in == IRQ_STATUS_ADDR))
    begin
      irq_status_next = irq_status_next & ~reg_wdata_in[IRQ_W-1:0];
    end
    // Events are applied after the clear so a coincident event survives.
    irq_status_next[IRQ_CYCLE_BIT] = irq_status_next[IRQ_CYCLE_BIT] | ovf_bus.sel_wrap;
    irq_status_next[IRQ_RISE_BIT]  = irq_status_next[IRQ_RISE_BIT] |
                                     |(capture_strobe_reg & rise_strobe_src);
    irq_status_next[IRQ_FALL_BIT]  = irq_status_next[IRQ_FALL_BIT] |
                                     |(capture_strobe_reg & ~rise_strobe_src);
  end

  // Remembers which edge produced each capture strobe.

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rise_strobe_src <= '0;
    end
    else
    begin
      rise_strobe_src <= rise_edge;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      irq_status_reg <= IRQ_RESET;
      irq_mask_reg   <= IRQ_RESET;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      if (reg_wr_in && (reg_addr_in == IRQ_MASK_ADDR))
      begin
        irq_mask_reg <= reg_wdata_in[IRQ_W-1:0];
      end
    end
  end

  assign irq_out                 = |(irq_status_reg & irq_mask_reg);
  assign counter_irq_out         = cycle_overflow_irq_enable_reg && cycle_overflow_flag_reg; // [R12]
  assign cycle_overflow_flag_out = cycle_overflow_flag_reg;
  assign watchdog_enable_out     = watchdog_enable_reg;
  assign auto_reload_select_out  = auto_reload_select_reg;

  // ----------
  // Read path
  // ----------
  // Read data appear only in the cycle after the strobe; zero otherwise, so an
  // unmapped address also reads zero.
  always_comb
  begin
    logic [NUM_MODULES-1:0] hit;
    hit        = mode_decode(reg_addr_in);
    rdata_next = 8'h00;
    for (int k = 0; k < NUM_MODULES; k++)
    begin
      if (hit[k])
      begin
        rdata_next = mode_reg[k];
      end
    end
    unique case (reg_addr_in)
      CYCLE_CFG_ADDR:
      begin
        rdata_next                                = 8'h00; // [R3]
        rdata_next[CFG_ARSEL_BIT]                 = auto_reload_select_reg;
        rdata_next[CFG_IRQ_EN_BIT]                = cycle_overflow_irq_enable_reg;
        rdata_next[CFG_OVF_BIT]                   = cycle_overflow_flag_reg;
        rdata_next[CFG_SEL_LSB +: CFG_SEL_W]      = cycle_length_select_reg;
      end
      IRQ_STATUS_ADDR: rdata_next = {5'h00, irq_status_reg};
      IRQ_MASK_ADDR:   rdata_next = {5'h00, irq_mask_reg};
      WDOG_CTRL_ADDR:  rdata_next = {7'h00, watchdog_enable_reg};
      default:         rdata_next = rdata_next;
    endcase
    if (!reg_rd_in)
    begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

endmodule // pcm_cycle_mode

`default_nettype wire

/* hdl/pcm_ovf_detect.sv */
`timescale 1ns/100ps
`default_nettype none

module pcm_ovf_detect
  import pcm_pkg::*;
(
  input  wire logic  clk_sys_in, // System clock.
  input  wire logic  rstn_in,    // Asynchronous reset, active low.
  pcm_ovf_if.detector ovf        // Counter in, wrap pulses out.
);

  logic [15:0] prev_reg;
  logic        sel_wrap_reg;
  logic        full_wrap_reg;
  logic [15:0] sel_mask;

  // Ones in the low 8 to 11 bits, per the cycle length code.
  function automatic logic [15:0] low_ones(input logic [1:0] sel);
    logic [4:0]  n;
    logic [16:0] m;
    n = CYCLE_BASE_BITS + {3'h0, sel};
    m = (17'h00001 << n) - 17'h00001;
    return m[15:0];
  endfunction

  assign sel_mask = low_ones(ovf.sel);

  // ----------
  // Carry out of the selected bit and out of bit 15
  // ----------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      prev_reg      <= 16'h0000;
      sel_wrap_reg  <= 1'b0;
      full_wrap_reg <= 1'b0;
    end
    else
    begin
      prev_reg      <= ovf.count;
      sel_wrap_reg  <= ((prev_reg & sel_mask) == sel_mask) &&
                       ((ovf.count & sel_mask) == 16'h0000); // [R1] [R4]
      full_wrap_reg <= (prev_reg == 16'hffff) && (ovf.count == 16'h0000); // [R6]
    end
  end

  assign ovf.sel_wrap  = sel_wrap_reg;
  assign ovf.full_wrap = full_wrap_reg;

endmodule // pcm_ovf_detect

`default_nettype wire

/* hdl/pcm_ovf_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface pcm_ovf_if;
  logic [15:0] count;
  logic [1:0]  sel;
  logic        sel_wrap;
  logic        full_wrap;

  modport detector (input count, input sel, output sel_wrap, output full_wrap);
  modport owner    (output count, output sel, input sel_wrap, input full_wrap);
endinterface : pcm_ovf_if

`default_nettype wire

/* hdl/pcm_pkg.sv */
`default_nettype none

package pcm_pkg;

  // ----------
  // Register bus geometry
  // ----------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ----------
  // Register offsets
  // ----------
  localparam logic [7:0] MODE0_ADDR      = 8'hda;
  localparam logic [7:0] MODE1_ADDR      = 8'hdb;
  localparam logic [7:0] MODE2_ADDR      = 8'hdc;
  localparam logic [7:0] CYCLE_CFG_ADDR  = 8'hf7;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'he1;
  localparam logic [7:0] IRQ_MASK_ADDR   = 8'he2;
  localparam logic [7:0] WDOG_CTRL_ADDR  = 8'he3;

  // ----------
  // Module mode register fields
  // ----------
  localparam int unsigned MODE_WIDE_BIT   = 7;
  localparam int unsigned MODE_CMP_BIT    = 6;
  localparam int unsigned MODE_RISE_BIT   = 5;
  localparam int unsigned MODE_FALL_BIT   = 4;
  localparam int unsigned MODE_MATCH_BIT  = 3;
  localparam int unsigned MODE_TOGGLE_BIT = 2;
  localparam int unsigned MODE_PWM_BIT    = 1;
  localparam int unsigned MODE_CCFIE_BIT  = 0;
  localparam logic [7:0]  MODE_RESET      = 8'h00;

  // ----------
  // Cycle configuration register fields
  // ----------
  localparam int unsigned CFG_ARSEL_BIT  = 7;
  localparam int unsigned CFG_IRQ_EN_BIT = 6;
  localparam int unsigned CFG_OVF_BIT    = 5;
  localparam int unsigned CFG_SEL_LSB    = 0;
  localparam int unsigned CFG_SEL_W      = 2;
  localparam logic [1:0]  CFG_SEL_RESET  = 2'h0;
  localparam logic        CFG_BIT_RESET  = 1'b0;

  // ----------
  // Interrupt status, mask and watchdog control
  // ----------
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_CYCLE_BIT  = 0;
  localparam int unsigned IRQ_RISE_BIT   = 1;
  localparam int unsigned IRQ_FALL_BIT   = 2;
  localparam logic [2:0]  IRQ_RESET      = 3'h0;
  localparam int unsigned WDOG_EN_BIT    = 0;

  // ----------
  // Cycle lengths
  // ----------
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned BITS_W          = 5;
  localparam logic [4:0]  CYCLE_BASE_BITS = 5'h08;
  localparam logic [4:0]  WIDE_CYCLE_BITS = 5'h10;

endpackage : pcm_pkg

`default_nettype wire

/* tb/pcm_cycle_mode_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module pcm_cycle_mode_checker
  import pcm_pkg::*;
#(
  parameter int unsigned NUM_MODULES = 3 // Module count.
)
(
  input wire logic                          clk_sys_in,              // Clock.
  input wire logic                          rstn_in,                 // Reset.
  input wire logic [ADDR_W-1:0]             reg_addr_in,             // Address.
  input wire logic [DATA_W-1:0]             reg_wdata_in,            // Write data.
  input wire logic                          reg_wr_in,               // Write strobe.
  input wire logic                          reg_rd_in,               // Read strobe.
  input wire logic [DATA_W-1:0]             reg_rdata_out,           // Read data.
  input wire logic [CNT_W-1:0]              main_counter_in,         // Counter.
  input wire logic                          cycle_overflow_flag_out, // Flag.
  input wire logic                          counter_irq_out,         // Request.
  input wire logic                          watchdog_enable_out,     // Watchdog.
  input wire logic [NUM_MODULES-1:0]        comparator_enable_out,   // Compare.
  input wire logic [NUM_MODULES-1:0]        wide_pwm_select_out,     // Wide PWM.
  input wire logic [NUM_MODULES-1:0]        pwm_enable_out,          // PWM.
  input wire logic [NUM_MODULES*BITS_W-1:0] pwm_cycle_bits_out       // Cycle bits.
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  // ----------
  // Helper logic
  // ----------
  // Any selected wrap also wraps the low byte, so one must precede a set.
  logic       cfg_wr;
  logic [7:0] lo_reg;
  logic [3:0] wrap_reg;
  assign cfg_wr = reg_wr_in && (reg_addr_in == CYCLE_CFG_ADDR);
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      lo_reg   <= 8'h00;
      wrap_reg <= 4'h0;
    end
    else
    begin
      lo_reg   <= main_counter_in[7:0];
      wrap_reg <= {wrap_reg[2:0], (lo_reg == 8'hff) && (main_counter_in[7:0] == 8'h00)};
    end
  end

  // ----------
  // Assertions
  // ----------
  chk_flag_cause: assert property ($rose(cycle_overflow_flag_out) |->
    (|wrap_reg) || $past(cfg_wr && reg_wdata_in[CFG_OVF_BIT])) else $error("flag rose uncaused");
  chk_flag_sticky: assert property (cycle_overflow_flag_out && !cfg_wr |=>
    cycle_overflow_flag_out) else $error("flag cleared by hardware");
  chk_flag_swset: assert property (cfg_wr && reg_wdata_in[CFG_OVF_BIT] |=>
    cycle_overflow_flag_out) else $error("software set lost");
  chk_cfg_read: assert property (reg_rd_in && reg_addr_in == CYCLE_CFG_ADDR |=>
    reg_rdata_out[4:2] == 3'h0 && reg_rdata_out[5] == $past(cycle_overflow_flag_out))
    else $error("bad cycle config read");
  chk_narrow_len: assert property (!wide_pwm_select_out[0] [*2] |->
    pwm_cycle_bits_out[4:0] >= 5'h08 && pwm_cycle_bits_out[4:0] <= 5'h0b)
    else $error("narrow length out of range");
  chk_wide_len: assert property (wide_pwm_select_out[1] [*2] |->
    pwm_cycle_bits_out[9:5] == WIDE_CYCLE_BITS) else $error("wide length wrong");
  chk_mode_write: assert property (reg_wr_in && reg_addr_in == MODE0_ADDR |=>
    comparator_enable_out[0] == $past(reg_wdata_in[MODE_CMP_BIT])
    && wide_pwm_select_out[0] == $past(reg_wdata_in[MODE_WIDE_BIT])
    && pwm_enable_out[0] == $past(reg_wdata_in[MODE_PWM_BIT])) else $error("mode write lost");
  chk_wdog_lock: assert property (watchdog_enable_out && reg_wr_in
    && reg_addr_in == MODE2_ADDR |=> $stable({comparator_enable_out[2],
    wide_pwm_select_out[2], pwm_enable_out[2]})) else $error("locked mode changed");
  chk_irq_flag: assert property (counter_irq_out |->
    cycle_overflow_flag_out) else $error("request without flag");
  chk_rd_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");

  cov_flag: cover property ($rose(cycle_overflow_flag_out) && !$past(cfg_wr));
  cov_irq: cover property ($rose(counter_irq_out));
  cov_lock: cover property (watchdog_enable_out && reg_wr_in && reg_addr_in == MODE2_ADDR);
endmodule // pcm_cycle_mode_checker

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import pcm_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [15:0] main_counter_in = 16'h0000;
  logic [2:0]  capture_pin_in = 3'h0;
  logic [7:0]  reg_rdata_out;
  logic        flag, cirq, irq, wdog, ars;
  logic [2:0]  cmp, wide, strobe, seen, mat, tog, pwm, ccf, cend, ends;
  logic [14:0] bits;
  logic [7:0]  exp_q[$];
  logic        pend = 1'b0;
  logic [7:0]  v;
  logic [15:0] r;
  logic [7:0]  maddr [3] = '{MODE0_ADDR, MODE1_ADDR, MODE2_ADDR};
  int          n_fail = 0;
  int          check_count = 0;

  pcm_cycle_mode i_dut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .main_counter_in(main_counter_in),
    .capture_pin_in(capture_pin_in), .cycle_overflow_flag_out(flag),
    .counter_irq_out(cirq), .irq_out(irq), .watchdog_enable_out(wdog),
    .auto_reload_select_out(ars), .comparator_enable_out(cmp), .match_enable_out(mat),
    .toggle_enable_out(tog), .pwm_enable_out(pwm), .wide_pwm_select_out(wide),
    .ccf_irq_enable_out(ccf), .capture_strobe_out(strobe), .pwm_cycle_bits_out(bits),
    .pwm_cycle_end_out(cend)
  );

  initial
  begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // ----------
  // Tasks
  // ----------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Each access ends at a falling edge, so outputs are settled for checks.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    if (w)
      reg_wr_in <= 1'b1;
    else
    begin
      reg_rd_in <= 1'b1;
      exp_q.push_back(d);
    end
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
  endtask

  task automatic wrap_at(input int n, input logic [15:0] hi);
    @(posedge clk_sys_in);
    main_counter_in <= (hi << n) | ((16'h1 << n) - 16'h1);
    @(posedge clk_sys_in);
    main_counter_in <= (hi << n) + (16'h1 << n);
    ends = 3'h0;
    repeat (4) @(negedge clk_sys_in) ends = ends | cend;
  endtask

  task automatic capt(input logic [2:0] p, input logic [2:0] e);
    @(posedge clk_sys_in);
    capture_pin_in <= p;
    seen = 3'h0;
    repeat (10)
    begin
      @(negedge clk_sys_in);
      seen = seen | strobe;
    end
    check(16'(seen), 16'(e));
  endtask

  // Read data stand only in the cycle after the read strobe.
  always @(posedge clk_sys_in)
  begin
    if (pend)
      check(16'(reg_rdata_out), 16'(exp_q.pop_front()));
    pend <= reg_rd_in;
  end

  initial
  begin
    #100us;
    n_fail++;
    end_sim();
  end

  // ----------
  // Tests
  // ----------
  initial
  begin
    void'($urandom(32'h1efdf81c));
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    acc(1'b0, CYCLE_CFG_ADDR, 8'h00);
    acc(1'b0, 8'h00, 8'h00);
    acc(1'b1, 8'h00, 8'hff);
    for (int k = 0; k < 3; k++)
    begin
      acc(1'b0, maddr[k], 8'h00);
      v = 8'($urandom);
      acc(1'b1, maddr[k], v);
      check(16'(cmp[k]), 16'(v[MODE_CMP_BIT]));
      check(16'(wide[k]), 16'(v[MODE_WIDE_BIT]));
      check(16'({mat[k], tog[k], pwm[k], ccf[k]}), 16'(v[3:0]));
      acc(1'b0, maddr[k], v);
    end
    $display("Mode register test done");
    acc(1'b1, MODE0_ADDR, 8'h20);
    acc(1'b1, MODE1_ADDR, 8'h10);
    acc(1'b1, MODE2_ADDR, 8'h30);
    capt(3'h7, 3'h5);
    capt(3'h0, 3'h6);
    $display("Capture test done");
    acc(1'b1, MODE0_ADDR, 8'h02);
    acc(1'b1, MODE1_ADDR, 8'h82);
    for (int s = 0; s < 4; s++)
    begin
      r = 16'($urandom) & 16'hff0f;
      acc(1'b1, CYCLE_CFG_ADDR, 8'(s));
      acc(1'b1, IRQ_STATUS_ADDR, 8'h07);
      wrap_at(7 + s, r & 16'hfffe);
      check(16'(flag), 16'h0);
      check(16'(ends), 16'h0);
      wrap_at(8 + s, r);
      check(16'(flag), 16'h1);
      check(16'(ends), 16'h1);
      check(16'(bits[4:0]), 16'(8 + s));
      check(16'(bits[9:5]), 16'h10);
      check(16'(bits[14:10]), 16'(8 + s));
      acc(1'b0, CYCLE_CFG_ADDR, 8'h20 | 8'(s));
    end
    $display("Cycle length test done");
    acc(1'b0, IRQ_STATUS_ADDR, 8'h01);
    check(16'(irq), 16'h0);
    acc(1'b1, IRQ_MASK_ADDR, 8'h01);
    check(16'(irq), 16'h1);
    acc(1'b1, IRQ_STATUS_ADDR, 8'h01);
    check(16'(irq), 16'h0);
    acc(1'b1, CYCLE_CFG_ADDR, 8'hff);
    check(16'(cirq), 16'h1);
    check(16'(ars), 16'h1);
    acc(1'b0, CYCLE_CFG_ADDR, 8'he3);
    acc(1'b1, CYCLE_CFG_ADDR, 8'h43);
    check(16'(cirq), 16'h0);
    wrap_at(11, 16'hffff);
    check(16'(cirq), 16'h1);
    check(16'(ends), 16'h3);
    @(posedge clk_sys_in) main_counter_in <= 16'h07ff;
    @(posedge clk_sys_in) main_counter_in <= 16'h0800;
    acc(1'b1, CYCLE_CFG_ADDR, 8'h43);
    check(16'(flag), 16'h1);
    $display("Interrupt test done");
    acc(1'b1, WDOG_CTRL_ADDR, 8'h01);
    check(16'(wdog), 16'h1);
    acc(1'b1, MODE2_ADDR, 8'h55);
    acc(1'b0, MODE2_ADDR, 8'h30);
    acc(1'b1, WDOG_CTRL_ADDR, 8'h00);
    acc(1'b1, MODE2_ADDR, 8'h55);
    acc(1'b0, MODE2_ADDR, 8'h55);
    $display("Watchdog lock test done");
    repeat (2) @(posedge clk_sys_in);
    end_sim();
  end
endmodule // tb_top

bind pcm_cycle_mode pcm_cycle_mode_checker #(.NUM_MODULES(NUM_MODULES)) i_chk (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .main_counter_in(main_counter_in),
  .cycle_overflow_flag_out(cycle_overflow_flag_out), .counter_irq_out(counter_irq_out),
  .watchdog_enable_out(watchdog_enable_out), .comparator_enable_out(comparator_enable_out),
  .wide_pwm_select_out(wide_pwm_select_out), .pwm_enable_out(pwm_enable_out),
  .pwm_cycle_bits_out(pwm_cycle_bits_out)
);

`default_nettype wire
